/* core/ibi_bus_interface.sv */
`timescale 1ns/10ps
`default_nettype none
// Operation
// - Data transceiver drives bus when second direction select high, receives when low.
// - Parallel poll (ATN with EOI) disables data drivers via active-low enable.
// - No parallel poll response; no status bit placed on data lines.
// - Inbound handshake lines reach controller only when direction selects enable them.
// - Inbound handshake buffers off while device itself drives DAC, DAV or RFD.
// - SRQ only when service requests enabled and measurement data ready.
// - EOI is received and flagged but never ends an incoming message.
// - Carriage return then line feed marks end of incoming message.
// - REN and IFC from system controller handled per 1978 bus standard.
// - ATN tags received bytes as interface commands rather than device data.
// - Address from five switches, seventh switch talk-only, sixth bit unused.
// - Active-low switch read puts inverted switch states on internal data bus.
// - EOI needs first select low; DAV in, DAC/RFD out need second select low.
// - Switches read at power-up and periodically by pulsing switch read enable.
module ibi_bus_interface #(
	parameter int SCAN_CYCLES = ibi_pkg::SCAN_PERIOD_CYCLES,
	parameter int DEPTH = ibi_pkg::FIFO_DEPTH
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire ibi_pkg::ibi_pins_t pins_in,
	output logic [7:0] dio_out,
	output logic dio_oe,
	output logic xcvr_enable_n,
	output logic dav_out,
	output logic dav_oe,
	output logic rfd_out,
	output logic rfd_oe,
	output logic dac_out,
	output logic dac_oe,
	output logic srq_out,
	output logic srq_oe,
	output logic switch_read_enable_n,
	output logic [7:0] internal_data_bus
);
	import ibi_pkg::*;

	// Synchronised pins
	ibi_pins_t pins_s;

	ibi_sync #(
		.WIDTH($bits(ibi_pins_t))
	) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.async_in(pins_in),
		.sync_out(pins_s)
	);

	// Control and status state
	logic [3:0] ctrl;
	logic [7:0] tx_byte;
	logic tx_pending;
	logic eoi_seen;
	logic msg_end;
	logic last_cr;
	logic [7:0] switch_image;
	ibi_hs_state_t hs_state;
	ibi_hs_state_t next_hs_state;
	ibi_scan_state_t scan_state;
	logic [31:0] scan_count;

	wire first_direction_select = ctrl[CTRL_FIRST_DIR];
	wire second_direction_select = ctrl[CTRL_SECOND_DIR];
	wire service_request_enable_command = ctrl[CTRL_SRQ_EN];
	wire data_ready = ctrl[CTRL_DATA_READY];

	// APB decode
	wire apb_access = psel && penable;
	wire apb_wr = apb_access && pwrite;
	wire apb_rd = apb_access && !pwrite;
	wire hit_ctrl = (paddr == ADDR_CTRL);
	wire hit_status = (paddr == ADDR_STATUS);
	wire hit_tx = (paddr == ADDR_TX);
	wire hit_rx = (paddr == ADDR_RX);
	wire hit_flags = (paddr == ADDR_FLAGS);
	wire hit_switch = (paddr == ADDR_SWITCH);
	wire hit_any = hit_ctrl || hit_status || hit_tx || hit_rx || hit_flags || hit_switch;
	wire wr_ctrl = apb_wr && hit_ctrl;
	wire wr_tx = apb_wr && hit_tx;
	wire wr_flags = apb_wr && hit_flags;
	wire rd_rx = apb_rd && hit_rx;

	// Parallel poll and line qualification
	wire parallel_poll = pins_s.atn && pins_s.eoi;
	wire eoi_rx = pins_s.eoi && !first_direction_select;
	wire dav_rx = pins_s.dav && !second_direction_select;
	wire rfd_rx = pins_s.rfd && second_direction_select;
	wire dac_rx = pins_s.dac && second_direction_select;
	wire ifc = pins_s.ifc;

	// Receive FIFO
	ibi_rx_word_t rx_in;
	ibi_rx_word_t rx_out;
	logic rx_in_ready;
	logic rx_out_valid;
	wire rx_push = (hs_state == HS_ACC_RFD) && dav_rx && rx_in_ready && !ifc;

	assign rx_in.atn = pins_s.atn;
	assign rx_in.data = pins_s.dio;

	ibi_fifo #(
		.WIDTH(RX_WIDTH),
		.DEPTH(DEPTH)
	) u_rx_fifo (
		.pclk(pclk),
		.presetn(presetn),
		.in_valid(rx_push),
		.in_ready(rx_in_ready),
		.in_data(rx_in),
		.out_valid(rx_out_valid),
		.out_ready(rd_rx),
		.out_data(rx_out)
	);

	// Message end detection on device data only
	wire data_byte = rx_push && !rx_in.atn;
	wire msg_end_set = data_byte && last_cr && (rx_in.data == CHAR_LF);
	wire eoi_set = eoi_rx && !parallel_poll;

	// Handshake sequencer
	always_comb begin
		next_hs_state = hs_state;
		unique case (hs_state)
			HS_IDLE: begin
				if (second_direction_select && tx_pending) begin
					next_hs_state = HS_SRC_WAIT_RFD;
				end else if (!second_direction_select && rx_in_ready) begin
					next_hs_state = HS_ACC_RFD;
				end
			end
			HS_SRC_WAIT_RFD: begin
				if (rfd_rx && !dac_rx) begin
					next_hs_state = HS_SRC_DAV;
				end
			end
			HS_SRC_DAV: begin
				if (dac_rx) begin
					next_hs_state = HS_IDLE;
				end
			end
			HS_ACC_RFD: begin
				if (rx_push) begin
					next_hs_state = HS_ACC_DAC;
				end
			end
			HS_ACC_DAC: begin
				if (!dav_rx) begin
					next_hs_state = HS_IDLE;
				end
			end
			default: begin
				next_hs_state = HS_IDLE;
			end
		endcase
		// Interface clear or a direction change abandons the transfer
		if (ifc) begin
			next_hs_state = HS_IDLE;
		end
		if (second_direction_select && (hs_state == HS_ACC_RFD || hs_state == HS_ACC_DAC)) begin
			next_hs_state = HS_IDLE;
		end
		if (!second_direction_select && (hs_state == HS_SRC_WAIT_RFD || hs_state == HS_SRC_DAV)) begin
			next_hs_state = HS_IDLE;
		end
	end

	wire src_done = (hs_state == HS_SRC_DAV) && (next_hs_state == HS_IDLE) && dac_rx;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hs_state <= HS_IDLE;
			dav_out <= 1'b0;
			rfd_out <= 1'b0;
			dac_out <= 1'b0;
		end else begin
			hs_state <= next_hs_state;
			dav_out <= (next_hs_state == HS_SRC_DAV);
			rfd_out <= (next_hs_state == HS_ACC_RFD);
			dac_out <= (next_hs_state == HS_ACC_DAC);
		end
	end

	// Pin drive enables follow the second direction select; transceiver enable follows parallel poll
	assign dav_oe = second_direction_select;
	assign rfd_oe = !second_direction_select;
	assign dac_oe = !second_direction_select;
	assign xcvr_enable_n = parallel_poll;
	assign dio_oe = second_direction_select && !xcvr_enable_n;
	assign dio_out = tx_byte;

	// Service request, open drain pulled low while requesting
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			srq_oe <= 1'b0;
		end else begin
			srq_oe <= service_request_enable_command && data_ready;
		end
	end
	assign srq_out = 1'b0;

	// Register writes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl <= CTRL_RESET;
			tx_byte <= 8'h00;
			tx_pending <= 1'b0;
		end else begin
			if (wr_ctrl) begin
				ctrl <= pwdata[3:0];
			end
			if (wr_tx && !tx_pending) begin
				tx_byte <= pwdata[7:0];
				tx_pending <= 1'b1;
			end else if (src_done || ifc) begin
				tx_pending <= 1'b0;
			end
		end
	end

	// Sticky flags, a new event wins over a clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			eoi_seen <= 1'b0;
			msg_end <= 1'b0;
			last_cr <= 1'b0;
		end else begin
			if (eoi_set) begin
				eoi_seen <= 1'b1;
			end else if (wr_flags && pwdata[FLAG_EOI_SEEN]) begin
				eoi_seen <= 1'b0;
			end
			if (msg_end_set) begin
				msg_end <= 1'b1;
			end else if (wr_flags && pwdata[FLAG_MSG_END]) begin
				msg_end <= 1'b0;
			end
			if (ifc) begin
				last_cr <= 1'b0;
			end else if (data_byte) begin
				last_cr <= (rx_in.data == CHAR_CR);
			end
		end
	end

	// Switch scan: read at reset release, then once per period
	wire [7:0] switch_drive = {1'b0, ~pins_s.sw_n[6], 1'b0, ~pins_s.sw_n[4:0]};
	assign internal_data_bus = switch_read_enable_n ? 8'h00 : switch_drive;
	wire scan_last = (scan_state == SCAN_READ) && (scan_count == 32'(SETTLE_CYCLES + 2));
	wire scan_start = (scan_state == SCAN_WAIT) && (scan_count == '0);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			scan_state <= SCAN_WAIT;
			scan_count <= '0;
			switch_read_enable_n <= 1'b1;
			switch_image <= 8'h00;
		end else begin
			unique case (scan_state)
				SCAN_WAIT: begin
					if (scan_start) begin
						scan_state <= SCAN_READ;
						switch_read_enable_n <= 1'b0;
					end else begin
						scan_count <= scan_count - 1'b1;
					end
				end
				SCAN_READ: begin
					if (scan_last) begin
						switch_image <= internal_data_bus;
						switch_read_enable_n <= 1'b1;
						scan_state <= SCAN_WAIT;
						scan_count <= 32'(SCAN_CYCLES - 1);
					end else begin
						scan_count <= scan_count + 1'b1;
					end
				end
				default: begin
					scan_state <= SCAN_WAIT;
					scan_count <= '0;
				end
			endcase
		end
	end

	wire [4:0] bus_address_switch_bits = switch_image[4:0];
	wire addressable_or_talk_only = switch_image[SW_TALK_ONLY];

	// Read data selection
	wire [31:0] status_word = {16'h0000, addressable_or_talk_only, 2'b00, bus_address_switch_bits,
		2'b00, hs_state != HS_IDLE, rx_out_valid, parallel_poll, pins_s.atn, pins_s.ifc, pins_s.ren};
	wire [31:0] rd_mux =
		hit_ctrl ? {28'h0000000, ctrl} :
		hit_status ? status_word :
		hit_tx ? {23'h0, tx_pending, tx_byte} :
		hit_rx ? {22'h0, rx_out_valid, rx_out.atn, rx_out.data} :
		hit_flags ? {30'h0, msg_end, eoi_seen} :
		hit_switch ? {24'h000000, switch_image} : 32'h00000000;

	assign pready = 1'b1;
	assign pslverr = apb_access && !hit_any;
	assign prdata = apb_rd ? rd_mux : 32'h00000000;
endmodule : ibi_bus_interface
`default_nettype wire

/* core/ibi_fifo.sv */
`timescale 1ns/10ps
`default_nettype none
module ibi_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 16
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] count;
	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;

	assign in_ready = (count != (AW+1)'(DEPTH));
	assign out_valid = (count != '0);
	assign out_data = mem[rd_ptr];

	always_ff @(posedge pclk) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			if (push) begin
				wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
			end
			count <= count + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule : ibi_fifo
`default_nettype wire

/* core/ibi_pkg.sv */
package ibi_pkg;
	// APB byte addresses
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_TX = 8'h08;
	localparam logic [7:0] ADDR_RX = 8'h0C;
	localparam logic [7:0] ADDR_FLAGS = 8'h10;
	localparam logic [7:0] ADDR_SWITCH = 8'h14;
	// Control register fields
	localparam int CTRL_FIRST_DIR = 0;
	localparam int CTRL_SECOND_DIR = 1;
	localparam int CTRL_SRQ_EN = 2;
	localparam int CTRL_DATA_READY = 3;
	localparam logic [3:0] CTRL_RESET = 4'h0;
	// Flag register fields
	localparam int FLAG_EOI_SEEN = 0;
	localparam int FLAG_MSG_END = 1;
	// Switch fields on the internal data bus
	localparam int SW_TALK_ONLY = 6;
	localparam int SW_UNUSED = 5;
	localparam logic [7:0] CHAR_CR = 8'h0D;
	localparam logic [7:0] CHAR_LF = 8'h0A;
	// Timing
	localparam int CLK_MHZ = 25;
	localparam int SCAN_PERIOD_US = 10000;
	localparam int SCAN_PERIOD_CYCLES = SCAN_PERIOD_US * CLK_MHZ;
	localparam int SETTLE_NS = 120;
	localparam int SETTLE_CYCLES = (SETTLE_NS * CLK_MHZ + 999) / 1000;
	localparam int FIFO_DEPTH = 16;
	localparam int RX_WIDTH = 9;

	typedef struct packed {
		logic [7:0] dio;
		logic dav;
		logic rfd;
		logic dac;
		logic eoi;
		logic atn;
		logic ren;
		logic ifc;
		logic [6:0] sw_n;
	} ibi_pins_t;

	typedef struct packed {
		logic atn;
		logic [7:0] data;
	} ibi_rx_word_t;

	typedef enum logic [2:0] {
		HS_IDLE = 3'b000,
		HS_SRC_WAIT_RFD = 3'b001,
		HS_SRC_DAV = 3'b010,
		HS_ACC_RFD = 3'b011,
		HS_ACC_DAC = 3'b100
	} ibi_hs_state_t;

	typedef enum logic [1:0] {
		SCAN_WAIT = 2'b00,
		SCAN_READ = 2'b01
	} ibi_scan_state_t;
endpackage : ibi_pkg

/* core/ibi_sync.sv */
`timescale 1ns/10ps
`default_nettype none
module ibi_sync #(
	parameter int WIDTH = 1
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] stage1;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stage1 <= '0;
			sync_out <= '0;
		end else begin
			stage1 <= async_in;
			sync_out <= stage1;
		end
	end
endmodule : ibi_sync
`default_nettype wire

/* tb/ibi_bus_interface_monitor.sv */
`timescale 1ns/10ps
`default_nettype none
module ibi_bus_interface_monitor (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire ibi_pkg::ibi_pins_t pins_in,
	input wire logic dio_oe,
	input wire logic xcvr_enable_n,
	input wire logic dav_out,
	input wire logic dav_oe,
	input wire logic rfd_out,
	input wire logic rfd_oe,
	input wire logic dac_out,
	input wire logic dac_oe,
	input wire logic srq_oe,
	input wire logic switch_read_enable_n,
	input wire logic [7:0] internal_data_bus
);
	import ibi_pkg::*;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic mapped;
	assign mapped = paddr inside {ADDR_CTRL, ADDR_STATUS, ADDR_TX, ADDR_RX, ADDR_FLAGS, ADDR_SWITCH};
	property p_dir;
		dav_oe != rfd_oe && rfd_oe == dac_oe && (!dio_oe || dav_oe);
	endproperty
	a_dir: assert property (p_dir) else $error("direction enables disagree");
	property p_ppoll;
		(pins_in.atn && pins_in.eoi)[*3] |-> xcvr_enable_n && !dio_oe;
	endproperty
	a_ppoll: assert property (p_ppoll) else $error("data drivers live in poll");
	property p_swoff;
		switch_read_enable_n |-> internal_data_bus == 8'h00;
	endproperty
	a_swoff: assert property (p_swoff) else $error("switch buffer not off");
	property p_swimg;
		(!switch_read_enable_n && $stable(pins_in.sw_n))[*3]
			|-> internal_data_bus == {1'b0, ~pins_in.sw_n[6], 1'b0, ~pins_in.sw_n[4:0]};
	endproperty
	a_swimg: assert property (p_swimg) else $error("switch image wrong");
	property p_scan;
		$fell(switch_read_enable_n) |-> !switch_read_enable_n[*3] ##[1:8] switch_read_enable_n;
	endproperty
	a_scan: assert property (p_scan) else $error("switch read window wrong");
	property p_srq;
		$rose(srq_oe) |-> $past(psel && penable && pwrite && paddr == ADDR_CTRL && pwdata[3:2] == 2'b11, 2);
	endproperty
	a_srq: assert property (p_srq) else $error("service request without cause");
	property p_acc;
		$rose(dac_out) |-> $fell(rfd_out) && rfd_oe && dac_oe;
	endproperty
	a_acc: assert property (p_acc) else $error("accept out of order");
	property p_src;
		$rose(dav_out) |-> dav_oe && dio_oe;
	endproperty
	a_src: assert property (p_src) else $error("source without drive");
	property p_apb;
		psel && penable && !mapped |-> pslverr && pready && prdata == 32'h0;
	endproperty
	a_apb: assert property (p_apb) else $error("unmapped access not refused");
endmodule : ibi_bus_interface_monitor
`default_nettype wire

/* tb/ibi_bus_interface_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module ibi_bus_interface_tb;
	import ibi_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, q;
	logic pready, pslverr, e, ok, dio_oe, xcvr_enable_n, dav_out, dav_oe, rfd_out, rfd_oe, dac_out, dac_oe;
	logic srq_out, srq_oe, switch_read_enable_n, bus_dav, bus_rfd, bus_dac, p_dav, p_rfd, p_dac;
	logic stall = 1'b0, listen = 1'b0, atn_l = 1'b0, eoi_l = 1'b0, ren_l = 1'b0, ifc_l = 1'b0;
	logic [7:0] dio_out, internal_data_bus, bus_dio, p_dio, got;
	logic [6:0] sw_l = 7'h2A;
	logic [9:0] rx_exp [4] = '{10'h245, 10'h321, 10'h20D, 10'h20A};
	ibi_pins_t pins;
	int mismatches = 0;
	int total_checks = 0;
	int cyc = 0;
	ibi_bus_interface #(.SCAN_CYCLES(20), .DEPTH(16)) ibi_bus_interface_inst (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pins_in(pins),
		.dio_out(dio_out), .dio_oe(dio_oe), .xcvr_enable_n(xcvr_enable_n), .dav_out(dav_out), .dav_oe(dav_oe),
		.rfd_out(rfd_out), .rfd_oe(rfd_oe), .dac_out(dac_out), .dac_oe(dac_oe), .srq_out(srq_out),
		.srq_oe(srq_oe), .switch_read_enable_n(switch_read_enable_n), .internal_data_bus(internal_data_bus)
	);
	ibi_bus_partner ibi_bus_partner_inst (
		.pclk(pclk), .stall(stall), .listen(listen), .bus_dio(bus_dio), .bus_dav(bus_dav), .bus_rfd(bus_rfd),
		.bus_dac(bus_dac), .p_dio(p_dio), .p_dav(p_dav), .p_rfd(p_rfd), .p_dac(p_dac), .got(got)
	);
	// Wired bus, pulled to unasserted when released
	assign bus_dio = (dio_oe && !xcvr_enable_n ? dio_out : 8'h00) | p_dio;
	assign bus_dav = (dav_oe && dav_out) | p_dav;
	assign bus_rfd = (rfd_oe && rfd_out) | p_rfd;
	assign bus_dac = (dac_oe && dac_out) | p_dac;
	assign pins = {bus_dio, bus_dav, bus_rfd, bus_dac, eoi_l, atn_l, ren_l, ifc_l, sw_l};
	always #20 pclk = ~pclk;
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : report_and_stop
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			mismatches++;
			report_and_stop();
		end
	end
	task automatic chk(input logic [31:0] s, input logic [31:0] x);
		total_checks++;
		if (s !== x) begin
			mismatches++;
			$display("CHECK FAILED %0t seen %h expected %h", $time, s, x);
		end
	endtask : chk
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic rd(input logic [7:0] a);
		apb(a, 1'b0, 32'h0);
	endtask : rd
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(a, 1'b1, d);
	endtask : wr
	task automatic t_reset;
		chk({dio_oe, dav_oe, rfd_oe, dac_oe, xcvr_enable_n, srq_oe}, 6'b001100);
		rd(ADDR_CTRL);
		chk(q, 32'h0);
		rd(8'h18);
		chk({e, q[7:0]}, 9'h100);
		$display("test reset done");
	endtask : t_reset
	task automatic t_switch;
		repeat (12) @(posedge pclk);
		rd(ADDR_SWITCH);
		chk(q[7:0], 8'h55);
		rd(ADDR_STATUS);
		chk(q[15:8], 8'h95);
		sw_l <= 7'h45;
		repeat (70) @(posedge pclk);
		rd(ADDR_SWITCH);
		chk(q[7:0], 8'h1A);
		$display("test switch done");
	endtask : t_switch
	task automatic t_rx;
		wr(ADDR_CTRL, 32'h1);
		eoi_l <= 1'b1;
		repeat (4) @(posedge pclk);
		rd(ADDR_FLAGS);
		chk(q[1:0], 2'b00);
		wr(ADDR_CTRL, 32'h0);
		@(posedge pclk);
		eoi_l <= 1'b1;
		ibi_bus_partner_inst.send(8'h45, ok);
		eoi_l <= 1'b0;
		rd(ADDR_FLAGS);
		chk(q[1:0], 2'b01);
		wr(ADDR_FLAGS, 32'h3);
		atn_l <= 1'b1;
		ibi_bus_partner_inst.send(8'h21, ok);
		atn_l <= 1'b0;
		ibi_bus_partner_inst.send(CHAR_CR, ok);
		ibi_bus_partner_inst.send(CHAR_LF, ok);
		rd(ADDR_FLAGS);
		chk(q[1:0], 2'b10);
		foreach (rx_exp[i]) begin
			rd(ADDR_RX);
			chk(q[9:0], rx_exp[i]);
		end
		$display("test rx done");
	endtask : t_rx
	task automatic t_fill;
		for (int i = 0; i < 17; i++) begin
			ibi_bus_partner_inst.send(8'h30 + i[7:0], ok);
			chk(ok, i < 16);
		end
		for (int i = 0; i < 16; i++) begin
			rd(ADDR_RX);
			chk(q[9:0], {2'b10, 8'h30 + i[7:0]});
		end
		rd(ADDR_RX);
		chk(q[9], 1'b0);
		$display("test fill done");
	endtask : t_fill
	task automatic t_tx;
		wr(ADDR_CTRL, 32'h2);
		stall <= 1'b1;
		listen <= 1'b1;
		@(posedge pclk);
		chk({dio_oe, dav_oe, rfd_oe, dac_oe}, 4'b1100);
		wr(ADDR_TX, 32'h5A);
		wr(ADDR_TX, 32'hA5);
		repeat (10) @(posedge pclk);
		chk(dav_out, 1'b0);
		rd(ADDR_TX);
		chk(q[8:0], 9'h15A);
		stall <= 1'b0;
		for (int n = 0; n < 50 && got !== 8'h5A; n++) @(posedge pclk);
		chk(got, 8'h5A);
		rd(ADDR_TX);
		chk(q[8], 1'b0);
		$display("test tx done");
	endtask : t_tx
	task automatic t_mgmt;
		atn_l <= 1'b1;
		eoi_l <= 1'b1;
		repeat (4) @(posedge pclk);
		chk({xcvr_enable_n, dio_oe, bus_dio}, 10'h200);
		atn_l <= 1'b0;
		eoi_l <= 1'b0;
		ren_l <= 1'b1;
		repeat (4) @(posedge pclk);
		rd(ADDR_STATUS);
		chk(q[3:0], 4'h1);
		ren_l <= 1'b0;
		ifc_l <= 1'b1;
		wr(ADDR_CTRL, 32'h4);
		repeat (2) @(posedge pclk);
		chk(srq_oe, 1'b0);
		wr(ADDR_CTRL, 32'h8);
		repeat (2) @(posedge pclk);
		chk(srq_oe, 1'b0);
		rd(ADDR_STATUS);
		chk(q[3:0], 4'h2);
		ifc_l <= 1'b0;
		wr(ADDR_CTRL, 32'hC);
		repeat (2) @(posedge pclk);
		chk({srq_oe, srq_out}, 2'b10);
		$display("test mgmt done");
	endtask : t_mgmt
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_switch();
		t_rx();
		t_fill();
		t_tx();
		t_mgmt();
		report_and_stop();
	end
endmodule : ibi_bus_interface_tb
bind ibi_bus_interface ibi_bus_interface_monitor ibi_bus_interface_monitor_inst (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pins_in(pins_in), .dio_oe(dio_oe),
	.xcvr_enable_n(xcvr_enable_n), .dav_out(dav_out), .dav_oe(dav_oe), .rfd_out(rfd_out), .rfd_oe(rfd_oe),
	.dac_out(dac_out), .dac_oe(dac_oe), .srq_oe(srq_oe), .switch_read_enable_n(switch_read_enable_n),
	.internal_data_bus(internal_data_bus)
);
`default_nettype wire

/* tb/ibi_bus_partner.sv */
`timescale 1ns/10ps
`default_nettype none
module ibi_bus_partner (
	input wire logic pclk,
	input wire logic stall,
	input wire logic listen,
	input wire logic [7:0] bus_dio,
	input wire logic bus_dav,
	input wire logic bus_rfd,
	input wire logic bus_dac,
	output logic [7:0] p_dio,
	output logic p_dav,
	output logic p_rfd,
	output logic p_dac,
	output logic [7:0] got
);
	initial begin
		p_dio = 8'h00;
		p_dav = 1'b0;
		got = 8'h00;
	end
	// Acceptor; stall holds ready low
	always @(posedge pclk) begin
		if (!listen) begin
			p_rfd <= 1'b0;
			p_dac <= 1'b0;
		end else if (bus_dav && !p_dac) begin
			got <= bus_dio;
			p_rfd <= 1'b0;
			p_dac <= 1'b1;
		end else if (!bus_dav) begin
			p_dac <= 1'b0;
			p_rfd <= !stall;
		end
	end
	// Source; gives up if ready never comes
	task automatic send(input logic [7:0] b, output logic ok);
		int n;
		n = 0;
		@(posedge pclk);
		p_dio <= b;
		while (!(bus_rfd && !bus_dac) && n < 40) begin
			@(posedge pclk);
			n++;
		end
		ok = n < 40;
		if (ok) begin
			@(posedge pclk);
			p_dav <= 1'b1;
			while (!bus_dac) @(posedge pclk);
			p_dav <= 1'b0;
			while (bus_dac) @(posedge pclk);
		end
		p_dio <= 8'h00;
	endtask : send
endmodule : ibi_bus_partner
`default_nettype wire
